// [src/pmc_cfg.svh]
// Function
// [R1] op_gate=0 ignores the operation on bit; op_gate=1 obeys it.
// [R2] pin_gate=0 ignores enable_pin; pin_gate=1 needs enable_pin asserted to start.
// [R3] pin_polarity 0 means enable_pin active low, 1 means active high.
// [R4] polarity takes effect only after store and power cycle, not on write.
// [R5] pin turn-off: fast_off=0 soft delay and ramp, fast_off=1 immediate off.
// [R6] clear-faults command clears all status bits together and releases the alert.
// [R7] clear-faults never restarts a unit latched off by a fault.
// [R8] fault still present after clearing sets its bit again and alerts again.
// [R9] host waits eight rise times plus turn-on delay before clear-faults.
// [R10] overvoltage latches low-side switch on; released by feedback low or clear.
// [R11] enable_pin low over 100 ns then high clears faults.
// [R12] every supported command stays readable whatever the write guard level.
// [R13] guard levels: only guard; plus operation; plus enable config and vout.
// [R14] guard write with several bits alerts, sets cml, and disables protection.
// [R15] restore under protection leaves protected registers untouched.
// [R16] store copies settings to eeprom; faults ignored while it runs.
// [R17] store or restore makes the bus unresponsive for about 100 ms.
// [R18] eeprom programming failure answers nack and sets cml and memory fault.
// [R19] restore reloads stored settings into unprotected registers only.
// [R20] host should stop the converter before a restore.
// [R21] write guard level is among the stored settings.
// [R22] autostart_select=0 runs whenever powered; 1 waits for configured gates.
// [R23] operation on bit 0 stops switching with both drivers low.
// [R24] start is the and of every enabled gate.
// [R25] a blocked write changes no register at all.
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

`define PMC_CMD_OPERATION   8'h01
`define PMC_CMD_ON_OFF      8'h02
`define PMC_CMD_CLEAR       8'h03
`define PMC_CMD_GUARD       8'h10
`define PMC_CMD_STORE       8'h11
`define PMC_CMD_RESTORE     8'h12
`define PMC_CMD_VOUT        8'h21
`define PMC_CMD_STATUS_BYTE 8'h78
`define PMC_CMD_STATUS_CML  8'h7e
`define PMC_CMD_VENDOR_F0   8'hf0

`define PMC_CFG_FAST_OFF  0
`define PMC_CFG_PIN_POL   1
`define PMC_CFG_PIN_GATE  2
`define PMC_CFG_OP_GATE   3
`define PMC_CFG_AUTOSTART 4
`define PMC_OP_ON         7
`define PMC_OP_SOFT       6
`define PMC_F0_OV_REL     0

`define PMC_GUARD_ONLY    3'h4
`define PMC_GUARD_OP      3'h2
`define PMC_GUARD_CFG     3'h1

`define PMC_SB_OFF        6
`define PMC_SB_OV         5
`define PMC_SB_CML        1
`define PMC_SB_OTHER      0
`define PMC_CML_IVC       7
`define PMC_CML_IVD       6
`define PMC_CML_MEM       4

`define PMC_CFG_RST       5'h1a
`define PMC_OP_RST        8'h00
`define PMC_GUARD_RST     3'h0
`define PMC_VOUT_RST      16'h0000
`define PMC_F0_RST        8'h00

`define PMC_NV_BYTES      5
`define PMC_NV_GUARD      3'h0
`define PMC_NV_CFG        3'h1
`define PMC_NV_VOUT_LO    3'h2
`define PMC_NV_VOUT_HI    3'h3
`define PMC_NV_F0         3'h4

`define PMC_CLK_MHZ       200
`define PMC_TOGGLE_NS     100
`define PMC_TOGGLE_CYC    ((`PMC_TOGGLE_NS * `PMC_CLK_MHZ + 999) / 1000)
`define PMC_TOGGLE_W      6
`define PMC_NVM_HOLD_MS   100
`define PMC_NVM_HOLD_CYC  (`PMC_NVM_HOLD_MS * 1000 * `PMC_CLK_MHZ)
`define PMC_HOLD_W        25

`endif

// [src/pmc_pkg.sv]
package pmc_pkg;
  typedef enum logic [1:0] {SQ_IDLE, SQ_REQ, SQ_HOLD} pmc_seq_e;
  typedef logic [7:0] pmc_byte_t;
endpackage

// [src/pmc_nvm_seq.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pmc_cfg.svh"
module pmc_nvm_seq #(
  parameter int unsigned HOLD_CYC = `PMC_NVM_HOLD_CYC
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             nrst,
  // request
  input  wire logic             start,
  input  wire logic             store,
  input  wire logic [39:0]      image,
  // eeprom port
  output logic                  ee_req,
  output logic                  ee_we,
  output logic [2:0]            ee_addr,
  output pmc_pkg::pmc_byte_t    ee_wdata,
  input  wire logic             ee_ack,
  input  wire logic             ee_err,
  input  wire pmc_pkg::pmc_byte_t ee_rdata,
  // results
  output logic                  ld_valid,
  output logic [2:0]            ld_idx,
  output pmc_pkg::pmc_byte_t    ld_data,
  output logic                  done,
  output logic                  fail,
  output logic                  busy,
  output logic                  storing
);
  import pmc_pkg::*;

  pmc_seq_e              st;
  logic [2:0]            idx;
  logic                  is_store;
  logic [`PMC_HOLD_W-1:0] hold;

  wire logic [2:0] idx_nxt = idx + 3'h1;
  wire logic       last    = (idx == 3'(`PMC_NV_BYTES - 1));
  wire logic       hold_end = (hold >= `PMC_HOLD_W'(HOLD_CYC - 1));

  assign storing = busy & is_store; // R16

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      st       <= SQ_IDLE;
      idx      <= 3'h0;
      is_store <= 1'b0;
      hold     <= '0;
      ee_req   <= 1'b0;
      ee_we    <= 1'b0;
      ee_addr  <= 3'h0;
      ee_wdata <= 8'h00;
      ld_valid <= 1'b0;
      ld_idx   <= 3'h0;
      ld_data  <= 8'h00;
      done     <= 1'b0;
      fail     <= 1'b0;
      busy     <= 1'b0;
    end else begin
      ld_valid <= 1'b0;
      done     <= 1'b0;
      unique case (st)
        SQ_IDLE: if (start) begin
          st       <= SQ_REQ;
          idx      <= 3'h0;
          is_store <= store;
          fail     <= 1'b0;
          busy     <= 1'b1; // R17
          hold     <= '0;
          ee_req   <= 1'b1;
          ee_we    <= store;
          ee_addr  <= 3'h0;
          ee_wdata <= image[7:0];
        end
        SQ_REQ: begin
          hold <= hold + 1'b1;
          if (ee_ack) begin
            if (!is_store) begin
              ld_valid <= 1'b1;
              ld_idx   <= idx;
              ld_data  <= ee_rdata;
            end
            if (ee_err) begin
              fail <= 1'b1; // R18
            end
            if (last) begin
              ee_req <= 1'b0;
              done   <= 1'b1;
              st     <= SQ_HOLD;
            end else begin
              idx      <= idx_nxt;
              ee_addr  <= idx_nxt;
              ee_wdata <= image[{idx_nxt, 3'h0} +: 8];
            end
          end
        end
        SQ_HOLD: if (hold_end) begin
          st   <= SQ_IDLE;
          busy <= 1'b0; // R17
        end else begin
          hold <= hold + 1'b1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// [src/pmc_onoff_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "pmc_cfg.svh"
module pmc_onoff_ctrl #(
  parameter int unsigned NVM_HOLD_CYC = `PMC_NVM_HOLD_CYC
) (
  // clock and reset
  input  wire logic               sys_clk,
  input  wire logic               nrst,
  // decoded command port
  input  wire logic               cmd_valid,
  input  wire logic               cmd_write,
  input  wire pmc_pkg::pmc_byte_t cmd_code,
  input  wire logic [15:0]        cmd_wdata,
  output logic                    rsp_valid,
  output logic                    rsp_nack,
  output logic [15:0]             rsp_rdata,
  output logic                    bus_busy,
  // pins from outside the clock domain
  input  wire logic               enable_pin,
  input  wire logic               feedback_low,
  input  wire logic               uvlo_ok,
  input  wire logic               ov_fault,
  input  wire logic               latch_fault,
  // alert, open drain
  output logic                    smbalert_out,
  output logic                    smbalert_oe,
  // power stage
  output logic                    convert_on,
  output logic                    soft_off,
  output logic                    low_side_switch,
  // eeprom port
  output logic                    ee_req,
  output logic                    ee_we,
  output logic [2:0]              ee_addr,
  output pmc_pkg::pmc_byte_t      ee_wdata,
  input  wire logic               ee_ack,
  input  wire logic               ee_err,
  input  wire pmc_pkg::pmc_byte_t ee_rdata
);
  import pmc_pkg::*;

  // guard decode shared by writes and restore
  function automatic logic wr_permitted(input logic [7:0] code,
                                        input logic [2:0] lvl);
    logic is_op;
    logic is_cfg;
    is_op  = (code == `PMC_CMD_OPERATION);
    is_cfg = (code == `PMC_CMD_ON_OFF) || (code == `PMC_CMD_VOUT);
    if (code == `PMC_CMD_GUARD) begin
      wr_permitted = 1'b1;
    end else begin
      unique case (lvl)
        `PMC_GUARD_ONLY: wr_permitted = 1'b0;
        `PMC_GUARD_OP:   wr_permitted = is_op;
        `PMC_GUARD_CFG:  wr_permitted = is_op | is_cfg;
        default:         wr_permitted = 1'b1;
      endcase
    end
  endfunction

  // synchronisers
  logic [4:0] pin_meta;
  logic [4:0] pin_sync;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
    end else begin
      pin_meta <= {enable_pin, feedback_low, uvlo_ok, ov_fault, latch_fault};
      pin_sync <= pin_meta;
    end
  end
  wire logic en_s   = pin_sync[4];
  wire logic fb_s   = pin_sync[3];
  wire logic uvlo_s = pin_sync[2];
  wire logic ov_s   = pin_sync[1];
  wire logic lf_s   = pin_sync[0];

  // configuration and status state
  pmc_byte_t   operation;
  logic [4:0]  enable_source_config;
  logic [2:0]  write_guard_level;
  logic [15:0] vout_command;
  pmc_byte_t   vendor_config_f0;
  logic        pin_pol_eff;
  logic        latched_off;
  logic        ov_flag;
  logic        lf_flag;
  logic        cml_flag;
  logic        ivc_flag;
  logic        ivd_flag;
  logic        mem_flag;
  logic        boot_pend;
  logic        boot_run;
  logic        nv_rsp_pend;
  logic [`PMC_TOGGLE_W-1:0] low_cnt;

  // eeprom sequencer
  logic        nv_ld_valid;
  logic [2:0]  nv_ld_idx;
  pmc_byte_t   nv_ld_data;
  logic        nv_done;
  logic        nv_fail;
  logic        nv_busy;
  logic        nv_storing;
  logic        nv_start;
  logic        nv_store;
  logic [39:0] nv_image;

  assign nv_image = {vendor_config_f0, vout_command[15:8], vout_command[7:0],
                     3'h0, enable_source_config,
                     write_guard_level, 5'h00}; // R21

  pmc_nvm_seq #(.HOLD_CYC(NVM_HOLD_CYC)) u_nvm (
    .sys_clk  (sys_clk),
    .nrst     (nrst),
    .start    (nv_start),
    .store    (nv_store),
    .image    (nv_image),
    .ee_req   (ee_req),
    .ee_we    (ee_we),
    .ee_addr  (ee_addr),
    .ee_wdata (ee_wdata),
    .ee_ack   (ee_ack),
    .ee_err   (ee_err),
    .ee_rdata (ee_rdata),
    .ld_valid (nv_ld_valid),
    .ld_idx   (nv_ld_idx),
    .ld_data  (nv_ld_data),
    .done     (nv_done),
    .fail     (nv_fail),
    .busy     (nv_busy),
    .storing  (nv_storing)
  );

  // command decode; while eeprom work runs only the running store or restore is answered
  wire logic acc  = cmd_valid & ~nv_busy & ~boot_pend; // R17
  wire logic wr   = acc & cmd_write;
  wire logic rd   = acc & ~cmd_write;
  wire logic c_op  = (cmd_code == `PMC_CMD_OPERATION);
  wire logic c_cfg = (cmd_code == `PMC_CMD_ON_OFF);
  wire logic c_clr = (cmd_code == `PMC_CMD_CLEAR);
  wire logic c_wg  = (cmd_code == `PMC_CMD_GUARD);
  wire logic c_sto = (cmd_code == `PMC_CMD_STORE);
  wire logic c_rst = (cmd_code == `PMC_CMD_RESTORE);
  wire logic c_vo  = (cmd_code == `PMC_CMD_VOUT);
  wire logic c_f0  = (cmd_code == `PMC_CMD_VENDOR_F0);
  wire logic c_sb  = (cmd_code == `PMC_CMD_STATUS_BYTE);
  wire logic c_sc  = (cmd_code == `PMC_CMD_STATUS_CML);
  wire logic c_wrable = c_op | c_cfg | c_clr | c_wg | c_sto | c_rst
                      | c_vo | c_f0;
  wire logic c_rdable = c_op | c_cfg | c_wg | c_vo | c_f0 | c_sb | c_sc;

  wire logic wr_allow = wr_permitted(cmd_code, write_guard_level)
                      | c_sto | c_rst; // R13 R15
  wire logic wr_bad   = wr & ~c_wrable;
  wire logic rd_bad   = rd & ~c_rdable;
  wire logic wr_block = wr & c_wrable & ~wr_allow; // R25
  wire logic op_bad   = cmd_wdata[`PMC_OP_ON] & cmd_wdata[`PMC_OP_SOFT];
  wire logic wr_ok    = wr & c_wrable & wr_allow & ~(c_op & op_bad);
  wire logic op_inv   = wr & c_op & wr_allow & op_bad;
  wire logic wg_multi = (cmd_wdata[7] & cmd_wdata[6])
                      | (cmd_wdata[7] & cmd_wdata[5])
                      | (cmd_wdata[6] & cmd_wdata[5]);
  wire logic wg_inv   = wr_ok & c_wg & wg_multi; // R14
  wire logic clr_cmd  = wr_ok & c_clr;
  wire logic sto_cmd  = wr_ok & c_sto;
  wire logic rst_cmd  = wr_ok & c_rst;
  wire logic boot_go  = boot_pend & ~nv_busy;
  assign nv_start = sto_cmd | rst_cmd | boot_go;
  assign nv_store = sto_cmd; // R16

  // a restore command writes only what the current guard level lets through; the boot restore writes all
  wire pmc_byte_t ld_code =
    (nv_ld_idx == `PMC_NV_GUARD) ? `PMC_CMD_GUARD :
    (nv_ld_idx == `PMC_NV_CFG)   ? `PMC_CMD_ON_OFF :
    (nv_ld_idx == `PMC_NV_F0)    ? `PMC_CMD_VENDOR_F0 : `PMC_CMD_VOUT;
  wire logic ld_ok = nv_ld_valid
    & (boot_run | wr_permitted(ld_code, write_guard_level)); // R15 R19
  wire logic ld_wg  = ld_ok & (nv_ld_idx == `PMC_NV_GUARD);
  wire logic ld_cfg = ld_ok & (nv_ld_idx == `PMC_NV_CFG);
  wire logic ld_vl  = ld_ok & (nv_ld_idx == `PMC_NV_VOUT_LO);
  wire logic ld_vh  = ld_ok & (nv_ld_idx == `PMC_NV_VOUT_HI);
  wire logic ld_f0  = ld_ok & (nv_ld_idx == `PMC_NV_F0);

  // enable pin toggle: long enough low, then high again
  wire logic toggle_clr = en_s & (low_cnt == `PMC_TOGGLE_W'(`PMC_TOGGLE_CYC));
  wire logic clr_any    = clr_cmd | toggle_clr; // R6 R11

  // faults, masked while a store runs
  wire logic ov_hit = ov_s & ~nv_storing; // R16
  wire logic lf_hit = lf_s & ~nv_storing; // R16
  wire logic nv_err = nv_done & nv_fail & ~boot_run;
  wire logic cml_set = wr_bad | rd_bad | op_inv | wg_inv | nv_err;
  wire logic alert_set = ov_hit | lf_hit | cml_set; // R8

  // run decision
  wire logic pin_asserted = pin_pol_eff ? en_s : ~en_s; // R3
  wire logic gate_pin = ~enable_source_config[`PMC_CFG_PIN_GATE]
                      | pin_asserted; // R2
  wire logic gate_op  = ~enable_source_config[`PMC_CFG_OP_GATE]
                      | operation[`PMC_OP_ON]; // R1 R23
  wire logic run_req  = ~enable_source_config[`PMC_CFG_AUTOSTART]
                      | (gate_pin & gate_op); // R22 R24
  wire logic restoring = nv_busy & ~nv_storing;
  wire logic pin_off  = enable_source_config[`PMC_CFG_PIN_GATE]
                      & ~pin_asserted;
  wire logic next_convert_on = run_req & uvlo_s & ~latched_off
                             & ~restoring & ~ov_hit & ~lf_hit;
  wire logic next_soft_off = pin_off
    ? ~enable_source_config[`PMC_CFG_FAST_OFF]
    : operation[`PMC_OP_SOFT]; // R5
  wire logic ov_rel = vendor_config_f0[`PMC_F0_OV_REL] & fb_s;
  wire logic next_low_side = ov_hit
    | (low_side_switch & ~(clr_any | ov_rel)); // R10

  // read data
  wire logic [7:0] status_byte = {1'b0, ~convert_on, ov_flag, 3'h0,
                                  cml_flag, lf_flag};
  wire logic [7:0] status_cml  = {ivc_flag, ivd_flag, 1'b0, mem_flag, 4'h0};
  wire logic [15:0] rd_data =
    c_op  ? {8'h00, operation} :
    c_cfg ? {11'h000, enable_source_config} :
    c_wg  ? {8'h00, write_guard_level, 5'h00} :
    c_vo  ? vout_command :
    c_f0  ? {8'h00, vendor_config_f0} :
    c_sb  ? {8'h00, status_byte} :
    c_sc  ? {8'h00, status_cml} : 16'h0000; // R12

  // registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      operation            <= `PMC_OP_RST;
      enable_source_config <= `PMC_CFG_RST;
      write_guard_level    <= `PMC_GUARD_RST;
      vout_command         <= `PMC_VOUT_RST;
      vendor_config_f0     <= `PMC_F0_RST;
      pin_pol_eff          <= 1'(`PMC_CFG_RST >> `PMC_CFG_PIN_POL);
    end else begin
      if ((wr_ok & c_op) ) operation <= cmd_wdata[7:0];
      if (wr_ok & c_cfg) begin
        enable_source_config <= cmd_wdata[4:0]; // R4
      end else if (ld_cfg) begin
        enable_source_config <= nv_ld_data[4:0];
      end
      if (boot_run & ld_cfg) begin
        pin_pol_eff <= nv_ld_data[`PMC_CFG_PIN_POL]; // R4
      end
      if (wr_ok & c_wg) begin
        write_guard_level <= cmd_wdata[7:5]; // R14
      end else if (ld_wg) begin
        write_guard_level <= nv_ld_data[7:5];
      end
      if (wr_ok & c_vo) begin
        vout_command <= cmd_wdata;
      end else begin
        if (ld_vl) vout_command[7:0]  <= nv_ld_data;
        if (ld_vh) vout_command[15:8] <= nv_ld_data;
      end
      if (wr_ok & c_f0) begin
        vendor_config_f0 <= cmd_wdata[7:0];
      end else if (ld_f0) begin
        vendor_config_f0 <= nv_ld_data;
      end
    end
  end

  // status flags: a set in the clearing cycle wins
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      ov_flag     <= 1'b0;
      lf_flag     <= 1'b0;
      cml_flag    <= 1'b0;
      ivc_flag    <= 1'b0;
      ivd_flag    <= 1'b0;
      mem_flag    <= 1'b0;
      smbalert_oe <= 1'b0;
      latched_off <= 1'b0;
      low_cnt     <= '0;
    end else begin
      ov_flag     <= ov_hit  | (ov_flag  & ~clr_any); // R6 R8
      lf_flag     <= lf_hit  | (lf_flag  & ~clr_any); // R6 R8
      cml_flag    <= cml_set | (cml_flag & ~clr_any); // R14 R18
      ivc_flag    <= wr_bad | rd_bad | (ivc_flag & ~clr_any);
      ivd_flag    <= op_inv | wg_inv | (ivd_flag & ~clr_any);
      mem_flag    <= nv_err  | (mem_flag & ~clr_any); // R18
      smbalert_oe <= alert_set | (smbalert_oe & ~clr_any); // R6 R14
      latched_off <= ov_hit | lf_hit | (latched_off & ~toggle_clr); // R7
      if (en_s) begin
        low_cnt <= '0;
      end else if (low_cnt != `PMC_TOGGLE_W'(`PMC_TOGGLE_CYC)) begin
        low_cnt <= low_cnt + 1'b1; // R11
      end
    end
  end

  // power stage, responses, boot restore
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      convert_on      <= 1'b0;
      soft_off        <= 1'b0;
      low_side_switch <= 1'b0;
      smbalert_out    <= 1'b0;
      rsp_valid       <= 1'b0;
      rsp_nack        <= 1'b0;
      rsp_rdata       <= 16'h0000;
      bus_busy        <= 1'b1;
      boot_pend       <= 1'b1;
      boot_run        <= 1'b0;
      nv_rsp_pend     <= 1'b0;
    end else begin
      convert_on      <= next_convert_on;
      soft_off        <= next_soft_off;
      low_side_switch <= next_low_side;
      bus_busy        <= nv_busy | boot_pend | nv_start; // R17
      if (boot_go) begin
        boot_pend <= 1'b0;
        boot_run  <= 1'b1;
      end else if (nv_done) begin
        boot_run  <= 1'b0;
      end
      rsp_valid <= 1'b0;
      rsp_nack  <= 1'b0;
      rsp_rdata <= 16'h0000;
      if (sto_cmd | rst_cmd) begin
        nv_rsp_pend <= 1'b1;
      end else if (nv_done & nv_rsp_pend) begin
        nv_rsp_pend <= 1'b0;
        rsp_valid   <= 1'b1;
        rsp_nack    <= nv_fail; // R18
      end else if (acc) begin
        rsp_valid <= 1'b1;
        rsp_nack  <= wr_bad | rd_bad | wr_block | op_inv; // R25
        rsp_rdata <= rd ? rd_data : 16'h0000; // R12
      end
    end
  end
endmodule
`default_nettype wire

// [test/pmc_onoff_props.sv]
`timescale 1ns/1ps
`default_nettype none
module pmc_onoff_props (
  // clock and reset
  input wire logic               sys_clk,
  input wire logic               nrst,
  // command port
  input wire logic               cmd_valid,
  input wire logic               cmd_write,
  input wire pmc_pkg::pmc_byte_t cmd_code,
  input wire logic [15:0]        cmd_wdata,
  input wire logic               rsp_valid,
  input wire logic               rsp_nack,
  input wire logic [15:0]        rsp_rdata,
  input wire logic               bus_busy,
  // faults and power stage
  input wire logic               ov_fault,
  input wire logic               latch_fault,
  input wire logic               smbalert_oe,
  input wire logic               low_side_switch,
  // eeprom port
  input wire logic               ee_req,
  input wire logic               ee_we,
  input wire logic [2:0]         ee_addr
);
  import pmc_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  wire take  = cmd_valid && !bus_busy;
  wire nvm   = cmd_code inside {8'h11, 8'h12};
  wire quiet = !ov_fault && !latch_fault;
  wire rd_ok = cmd_code inside {8'h01, 8'h02, 8'h10, 8'h21, 8'h78,
                                8'h7e, 8'hf0};
  sequence s_clear;
    take && cmd_write && cmd_code == 8'h03;
  endsequence
  AST_WRITE_RSP:
    assert property (take && cmd_write && !nvm |=> rsp_valid
      && rsp_rdata == 16'h0000) else $error("write answer missing");
  AST_READ_ACK:
    assert property (take && !cmd_write && rd_ok |=> rsp_valid
      && !rsp_nack) else $error("read refused");
  AST_NVM_BUSY:
    assert property (take && cmd_write && nvm |=> bus_busy[*8])
    else $error("eeprom hold broken");
  AST_STORE_EE:
    assert property (take && cmd_write && cmd_code == 8'h11
      |=> ee_req && ee_we && ee_addr == 3'h0) else $error("store start");
  AST_CLEAR:
    assert property (quiet[*4] ##0 s_clear |=> !smbalert_oe)
    else $error("alert not released by clear");
  AST_REFAULT:
    assert property (latch_fault[*4] ##0 s_clear |=> ##[0:2] smbalert_oe)
    else $error("fault not reported again");
  AST_OV_LATCH:
    assert property ((ov_fault && !bus_busy)[*4] |-> ##[0:2]
      low_side_switch) else $error("low side not latched");
  AST_GUARD_MULTI:
    assert property (take && cmd_write && cmd_code == 8'h10
      && $countones(cmd_wdata[7:5]) > 1 |=> !rsp_nack ##[0:2] smbalert_oe)
    else $error("bad guard value not flagged");
endmodule
bind pmc_onoff_ctrl pmc_onoff_props u_pmc_onoff_props (.*);
`default_nettype wire

// [test/pmc_ee_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pmc_ee_model (
  // clock
  input wire logic                sys_clk,
  // eeprom access
  input wire logic                ee_req,
  input wire logic                ee_we,
  input wire logic [2:0]          ee_addr,
  input wire pmc_pkg::pmc_byte_t  ee_wdata,
  output var logic                ee_ack = 1'b0,
  output var logic                ee_err = 1'b0,
  output var pmc_pkg::pmc_byte_t  ee_rdata = 8'h00,
  // bench control
  input wire logic                slow,
  input wire logic                fail_next
);
  import pmc_pkg::*;
  pmc_byte_t mem [5];
  int        dly = 0;
  always @(posedge sys_clk) begin
    ee_ack <= 1'b0;
    ee_err <= 1'b0;
    ee_rdata <= ~ee_rdata;
    if (ee_req && !ee_ack && dly < (slow ? 5 : 0)) dly <= dly + 1;
    else if (ee_req && !ee_ack) begin
      dly <= 0;
      ee_ack <= 1'b1;
      ee_err <= fail_next;
      ee_rdata <= mem[ee_addr];
      if (ee_we && !fail_next) mem[ee_addr] <= ee_wdata;
    end
  end
endmodule
`default_nettype wire

// [test/power_module_onoff_protect_nvm_cmds_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module power_module_onoff_protect_nvm_cmds_tb;
  import pmc_pkg::*;
  logic        sys_clk = 0, nrst = 0, cmd_valid = 0, cmd_write = 0;
  pmc_byte_t   cmd_code = 8'h00;
  logic [15:0] cmd_wdata = 16'h0000;
  logic        enable_pin = 1, feedback_low = 0, uvlo_ok = 1;
  logic        ov_fault = 0, latch_fault = 0, slow = 0, fail_next = 0;
  logic        rsp_valid, rsp_nack, bus_busy, smbalert_out, smbalert_oe;
  logic        convert_on, soft_off, low_side_switch, ee_req, ee_we;
  logic        ee_ack, ee_err, nk, pol;
  logic [2:0]  ee_addr;
  pmc_byte_t   ee_wdata, ee_rdata, m [5];
  logic [15:0] rsp_rdata, rd, op, cfg, grd, vout, f0;
  int          err_count = 0, check_count = 0, seed = 32'h3765;
  pmc_byte_t   gl [5] = '{8'h80, 8'h40, 8'h20, 8'he0, 8'h00};
  pmc_byte_t   rc [5] = '{8'h01, 8'h02, 8'h10, 8'h21, 8'hf0};
  pmc_onoff_ctrl #(.NVM_HOLD_CYC(200)) u_pmc_onoff_ctrl (.*);
  pmc_ee_model u_pmc_ee_model (.*);
  initial forever #2.5 sys_clk = ~sys_clk;
  task automatic chk(input logic [16:0] s, e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic cmd(input logic w, input pmc_byte_t c, logic [15:0] d);
    int k;
    k = 0;
    #1;
    while (bus_busy !== 1'b0 && k < 3000) begin
      tick(1);
      #1;
      k++;
    end
    tick(1);
    cmd_valid <= 1;
    cmd_write <= w;
    cmd_code <= c;
    cmd_wdata <= d;
    tick(1);
    cmd_valid <= 0;
    #1;
    while (rsp_valid !== 1'b1 && k < 3500) begin
      tick(1);
      #1;
      k++;
    end
    rd = rsp_rdata;
    nk = rsp_nack;
  endtask
  function automatic logic al(input pmc_byte_t c);
    logic [2:0] g;
    g = grd[7:5];
    if (c == 8'h10 || !(g inside {3'h4, 3'h2, 3'h1})) return 1;
    if (g == 3'h2) return c == 8'h01;
    return g == 3'h1 && c inside {8'h01, 8'h02, 8'h21};
  endfunction
  function automatic logic [15:0] xr(input pmc_byte_t c);
    case (c)
      8'h01: return op;
      8'h02: return cfg;
      8'h10: return grd;
      8'h21: return vout;
      default: return f0;
    endcase
  endfunction
  function automatic logic [1:0] cv();
    logic pa;
    pa = pol == enable_pin;
    return {uvlo_ok && (!cfg[4] || (!cfg[2] || pa) && (!cfg[3] || op[7])),
            cfg[2] && !pa ? !cfg[0] : op[6]};
  endfunction
  task automatic wr(input pmc_byte_t c, input logic [15:0] d);
    logic ok;
    ok = al(c);
    cmd(1, c, d);
    chk(17'(nk), 17'(!ok));
    if (ok && c == 8'h01) op = d;
    if (ok && c == 8'h02) cfg = d;
    if (ok && c == 8'h10) grd = d;
    if (ok && c == 8'h21) vout = d;
    if (ok && c == 8'hf0) f0 = d;
  endtask
  task automatic rall();
    foreach (rc[i]) begin
      cmd(0, rc[i], 16'h0000);
      chk({nk, rd}, {1'b0, xr(rc[i])});
    end
  endtask
  initial begin
    m = '{8'h00, 8'($random(seed)) & 8'h1f, 8'($random(seed)),
          8'($random(seed)) & 8'h03, 8'h00};
    u_pmc_ee_model.mem = m;
    {op, grd, f0} = 48'h0;
    cfg = 16'(m[1]);
    vout = {m[3], m[2]};
    pol = m[1][1];
    tick(8);
    nrst <= 1;
    rall();
    $display("boot test done");
    repeat (12) begin
      wr(8'h02, 16'($random(seed)) & 16'h001f);
      wr(8'h01, 16'($random(seed)) & 16'h0080);
      tick(1);
      enable_pin <= 1'($random(seed));
      uvlo_ok <= ($random(seed) & 3) != 0;
      tick(8);
      #1;
      chk(17'({convert_on, soft_off}), 17'(cv()));
    end
    tick(1);
    uvlo_ok <= 1;
    $display("gating test done");
    foreach (gl[i]) begin
      wr(8'h10, 16'(gl[i]));
      wr(8'h01, 16'h0040);
      wr(8'h02, 16'($random(seed)) & 16'h001f);
      wr(8'h21, 16'($random(seed)) & 16'h03ff);
      wr(8'hf0, 16'($random(seed)) & 16'h0001);
      rall();
      if (gl[i] == 8'he0) begin
        cmd(0, 8'h78, 16'h0000);
        chk(17'({rd[1], smbalert_oe}), 17'h3);
      end
    end
    cmd(1, 8'h03, 16'h0000);
    cmd(0, 8'h7e, 16'h0000);
    chk({smbalert_oe, rd}, 17'h0);
    $display("guard test done");
    wr(8'h10, 16'h0020);
    cmd(1, 8'h11, 16'h0000);
    chk(17'({nk, bus_busy}), 17'h1);
    m = '{grd[7:0], cfg[7:0], vout[7:0], vout[15:8], f0[7:0]};
    foreach (m[i]) chk(17'(u_pmc_ee_model.mem[i]), 17'(m[i]));
    wr(8'h01, 16'h0000);
    wr(8'h21, 16'h0155);
    wr(8'h10, 16'h0000);
    wr(8'hf0, ~f0 & 16'h0001);
    wr(8'h10, 16'h0020);
    slow <= 1;
    cmd(1, 8'h12, 16'h0000);
    chk(17'(nk), 17'h0);
    vout = {m[3], m[2]};
    cfg = 16'(m[1]);
    rall();
    fail_next <= 1;
    cmd(1, 8'h11, 16'h0000);
    fail_next <= 0;
    chk(17'(nk), 17'h1);
    cmd(0, 8'h78, 16'h0000);
    chk(17'(rd[1]), 17'h1);
    cmd(0, 8'h7e, 16'h0000);
    chk(17'(rd[4]), 17'h1);
    $display("eeprom test done");
    wr(8'h10, 16'h0000);
    wr(8'h02, 16'h0000);
    wr(8'hf0, 16'h0000);
    for (int r = 0; r < 2; r++) begin
      tick(1);
      ov_fault <= 1;
      tick(6);
      ov_fault <= 0;
      feedback_low <= r;
      tick(6);
      chk(17'(low_side_switch), 17'(!r));
      if (r == 0) cmd(1, 8'h03, 16'h0000);
      tick(3);
      chk(17'({low_side_switch, convert_on}), 17'h0);
      if (r == 0) wr(8'hf0, 16'h0001);
    end
    feedback_low <= 0;
    latch_fault <= 1;
    tick(6);
    cmd(1, 8'h03, 16'h0000);
    tick(3);
    chk(17'(smbalert_oe), 17'h1);
    latch_fault <= 0;
    enable_pin <= 0;
    tick(25);
    enable_pin <= 1;
    tick(8);
    chk(17'({convert_on, smbalert_oe, smbalert_out}), 17'h4);
    $display("fault test done");
    test_done();
  end
  initial begin
    tick(30000);
    err_count++;
    test_done();
  end
endmodule
`default_nettype wire
